// File: hw/pcs_pkg.sv
package pcs_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned POS_W  = 10;
  localparam int unsigned BASE_W = 12;
  localparam int unsigned NUM_INSETS = 16;

  // register byte offsets
  localparam logic [5:0] ROLE_OFF    = 6'h00;
  localparam logic [5:0] LAYOUT_OFF  = 6'h04;
  localparam logic [5:0] CMD_OFF     = 6'h08;
  localparam logic [5:0] STATUS_OFF  = 6'h0c;
  localparam logic [5:0] LINOFF_OFF  = 6'h10;
  localparam logic [5:0] PIXOFF_OFF  = 6'h14;
  localparam logic [5:0] HSTART_OFF  = 6'h18;
  localparam logic [5:0] VSTART_OFF  = 6'h1c;
  localparam logic [5:0] INSLIN_OFF  = 6'h20;
  localparam logic [5:0] INSPIX_OFF  = 6'h24;
  localparam logic [5:0] LIVE_OFF    = 6'h28;

  // status field positions
  localparam int unsigned ST_PENDING_BIT = 0;
  localparam int unsigned ST_DISPLAY_BIT = 1;
  localparam int unsigned ST_FILL_BIT    = 2;

  // chip roles
  localparam logic [7:0] ROLE_WRITER = 8'h01;
  localparam logic [7:0] ROLE_MAIN   = 8'h05;

  // command opcodes, upper nibble
  localparam logic [3:0] OPC_FILL_BG    = 4'hc;
  localparam logic [3:0] OPC_FRAME      = 4'ha;
  localparam logic [3:0] OPC_LIVE       = 4'h8;
  localparam logic [3:0] OPC_STOP       = 4'h9;
  localparam logic [3:0] OPC_FILL_BG_NF = 4'hd;
  localparam logic [3:0] OPC_LIVE_NF    = 4'he;
  localparam logic [3:0] OPC_DISP_ON    = 4'h8;
  localparam logic [3:0] OPC_DISP_OFF   = 4'h9;

  // reset values
  localparam logic [7:0]       ROLE_RST   = 8'h00;
  localparam logic [7:0]       LAYOUT_RST = 8'h00;
  localparam logic [POS_W-1:0] GROUP_OFFSET_RST = 10'h000;
  localparam logic [POS_W-1:0] WINDOW_RST = 10'h000;
  localparam logic [POS_W-1:0] INS_LINES_RST = 10'h048;
  localparam logic [POS_W-1:0] INS_PIX_RST   = 10'h0b4;

  // fill kinds
  localparam logic [1:0] FILL_BG    = 2'h0;
  localparam logic [1:0] FILL_FRAME = 2'h1;
  localparam logic [1:0] FILL_BG_NF = 2'h2;

  // inset table operations
  localparam logic [1:0] OP_NONE     = 2'h0;
  localparam logic [1:0] OP_START_FR = 2'h1;
  localparam logic [1:0] OP_START_NF = 2'h2;
  localparam logic [1:0] OP_STOP     = 2'h3;

  // timing: one field of fill at 10 MHz
  localparam longint unsigned CLK_PERIOD_NS = 100;
  localparam longint unsigned FILL_TIME_NS  = 20000000;
  localparam int unsigned FILL_CYCLES = int'(FILL_TIME_NS / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    PCS_IDLE   = 4'h1,
    PCS_DECODE = 4'h2,
    PCS_FILL   = 4'h4,
    PCS_DONE   = 4'h8
  } pcs_state_t;
endpackage

// File: hw/pcs_fill_engine.sv
`timescale 1ns/1ns
module pcs_fill_engine #(
  parameter int unsigned FILL_CYCLES = pcs_pkg::FILL_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  generate
    if (FILL_CYCLES < 1) begin : g_bad
      $error("fill length must be at least one cycle");
    end
  endgenerate

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [31:0] count;
  } pcs_fill_t;

  pcs_fill_t s;
  pcs_fill_t n;

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (s.busy) begin
      if (s.count == 32'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.count = s.count - 32'h1;
      end
    end else if (start) begin
      n.busy  = 1'b1;
      n.count = 32'(FILL_CYCLES);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
endmodule

// File: hw/pcs_inset_table.sv
`timescale 1ns/1ns
module pcs_inset_table #(
  parameter int unsigned NUM_INSETS = pcs_pkg::NUM_INSETS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic [1:0]            op,
  input  wire logic [3:0]            idx,
  output logic [NUM_INSETS-1:0]      live_mask,
  output logic [NUM_INSETS-1:0]      framed_mask
);
  generate
    if (NUM_INSETS != 16) begin : g_bad
      $error("index field addresses exactly sixteen insets");
    end
  endgenerate

  typedef struct packed {
    logic [NUM_INSETS-1:0] live;
    logic [NUM_INSETS-1:0] framed;
  } pcs_table_t;

  pcs_table_t            s;
  pcs_table_t            n;
  logic [NUM_INSETS-1:0] next_live;
  logic [NUM_INSETS-1:0] next_framed;

  // per inset: stop freezes content but keeps its frame style
  for (genvar i = 0; i < NUM_INSETS; i++) begin : g_inset
    logic hit;
    assign hit = (idx == 4'(i)) && (op != pcs_pkg::OP_NONE);
    assign next_live[i]   = hit ? (op != pcs_pkg::OP_STOP) : s.live[i];
    assign next_framed[i] = (hit && op != pcs_pkg::OP_STOP) ?
                            (op == pcs_pkg::OP_START_FR) : s.framed[i];
  end

  always_comb begin
    n = s;
    n.live   = next_live;
    n.framed = next_framed;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign live_mask   = s.live;
  assign framed_mask = s.framed;
endmodule

// File: hw/pcs_sequencer.sv
// Operation
// (R01) up to 4x4 grid uses zero offsets
// (R02) host regroups larger grids, sets offsets
// (R03) host waits pending clear between commands
// (R04) writer 0xc0 fills inset background framed
// (R05) writer 0xa0 draws inset frame colour
// (R06) writer 0x80 starts live inset writing
// (R07) writer 0x90 stops live, freezes inset
// (R08) main 0x80 turns inset display on
// (R09) main 0x90 turns inset display off
// (R10) low nibble: bits 1:0 col, 3:2 row
// (R11) host sets role 0x05, layout 0x46
// (R12) host cycles insets for tuner scanning
// (R13) window start moves after live start
// (R14) new line offset relocates inset group
// (R15) no range check or clamping of settings
// (R16) distinct no-frame fill and live commands
// (R17) pending set on write, cleared when done
`timescale 1ns/1ns
module pcs_sequencer #(
  parameter int unsigned FILL_CYCLES = pcs_pkg::FILL_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic [pcs_pkg::ADDR_W-1:0]  addr,
  input  wire logic [pcs_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic [pcs_pkg::DATA_W-1:0]       rdata,
  output logic                             command_pending_flag,
  output logic                             display_enable,
  output logic                             fill_busy,
  output logic [1:0]                       fill_kind,
  output logic [pcs_pkg::BASE_W-1:0]       fill_line_base,
  output logic [pcs_pkg::BASE_W-1:0]       fill_pixel_base,
  output logic [pcs_pkg::POS_W-1:0]        horiz_window_start,
  output logic [pcs_pkg::POS_W-1:0]        vert_window_start,
  output logic [7:0]                       inset_layout_select,
  output logic [pcs_pkg::NUM_INSETS-1:0]   inset_live_mask,
  output logic [pcs_pkg::NUM_INSETS-1:0]   inset_framed_mask
);
  localparam int unsigned PW = pcs_pkg::POS_W;
  localparam int unsigned BW = pcs_pkg::BASE_W;

  typedef struct packed {
    pcs_pkg::pcs_state_t         state;
    logic [7:0]                  role;
    logic [7:0]                  layout;
    logic [7:0]                  cmd;
    logic                        pending;
    logic [PW-1:0]               line_off;
    logic [PW-1:0]               pix_off;
    logic [PW-1:0]               hstart;
    logic [PW-1:0]               vstart;
    logic [PW-1:0]               ins_lines;
    logic [PW-1:0]               ins_pix;
    logic                        display_on;
    logic                        fill_start;
    logic [1:0]                  fill_kind;
    logic [BW-1:0]               fill_line;
    logic [BW-1:0]               fill_pix;
    logic [1:0]                  tbl_op;
    logic [3:0]                  tbl_idx;
    logic [pcs_pkg::DATA_W-1:0]  rdata;
  } pcs_seq_t;

  pcs_seq_t                     s;
  pcs_seq_t                     n;
  logic                         eng_busy;
  logic                         eng_done;
  logic [pcs_pkg::NUM_INSETS-1:0] live_mask;
  logic [pcs_pkg::NUM_INSETS-1:0] framed_mask;
  logic                         cmd_wr;
  logic                         is_writer;
  logic                         is_main;
  logic [3:0]                   opc;
  logic [1:0]                   col;
  logic [1:0]                   row;

  pcs_fill_engine #(
    .FILL_CYCLES (FILL_CYCLES)
  ) u_fill (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (s.fill_start),
    .busy    (eng_busy),
    .done    (eng_done)
  );

  pcs_inset_table #(
    .NUM_INSETS (pcs_pkg::NUM_INSETS)
  ) u_table (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .op          (s.tbl_op),
    .idx         (s.tbl_idx),
    .live_mask   (live_mask),
    .framed_mask (framed_mask)
  );

  // a write while busy is dropped: the host is expected to poll first
  assign cmd_wr    = wr && (addr == pcs_pkg::CMD_OFF) && !s.pending;
  assign is_writer = (s.role == pcs_pkg::ROLE_WRITER);
  assign is_main   = (s.role == pcs_pkg::ROLE_MAIN);
  assign opc       = s.cmd[7:4];
  // (R10) index split
  assign col       = s.cmd[1:0];
  assign row       = s.cmd[3:2];

  always_comb begin
    n = s;
    n.fill_start = 1'b0;
    n.tbl_op     = pcs_pkg::OP_NONE;
    n.rdata      = '0;

    // (R15) settings stored unchecked
    if (wr) begin
      unique case (addr)
        pcs_pkg::ROLE_OFF:   n.role      = wdata[7:0];
        pcs_pkg::LAYOUT_OFF: n.layout    = wdata[7:0];
        pcs_pkg::LINOFF_OFF: n.line_off  = wdata[PW-1:0];
        pcs_pkg::PIXOFF_OFF: n.pix_off   = wdata[PW-1:0];
        // (R13) window moves live
        pcs_pkg::HSTART_OFF: n.hstart    = wdata[PW-1:0];
        pcs_pkg::VSTART_OFF: n.vstart    = wdata[PW-1:0];
        pcs_pkg::INSLIN_OFF: n.ins_lines = wdata[PW-1:0];
        pcs_pkg::INSPIX_OFF: n.ins_pix   = wdata[PW-1:0];
        default: ;
      endcase
    end

    if (rd) begin
      unique case (addr)
        pcs_pkg::ROLE_OFF:   n.rdata = 16'(s.role);
        pcs_pkg::LAYOUT_OFF: n.rdata = 16'(s.layout);
        pcs_pkg::CMD_OFF:    n.rdata = 16'(s.cmd);
        pcs_pkg::STATUS_OFF: begin
          n.rdata[pcs_pkg::ST_PENDING_BIT] = s.pending;
          n.rdata[pcs_pkg::ST_DISPLAY_BIT] = s.display_on;
          n.rdata[pcs_pkg::ST_FILL_BIT]    = eng_busy;
        end
        pcs_pkg::LINOFF_OFF: n.rdata = 16'(s.line_off);
        pcs_pkg::PIXOFF_OFF: n.rdata = 16'(s.pix_off);
        pcs_pkg::HSTART_OFF: n.rdata = 16'(s.hstart);
        pcs_pkg::VSTART_OFF: n.rdata = 16'(s.vstart);
        pcs_pkg::INSLIN_OFF: n.rdata = 16'(s.ins_lines);
        pcs_pkg::INSPIX_OFF: n.rdata = 16'(s.ins_pix);
        pcs_pkg::LIVE_OFF:   n.rdata = 16'(live_mask);
        default:             n.rdata = '0;
      endcase
    end

    unique case (s.state)
      pcs_pkg::PCS_IDLE: begin
        if (cmd_wr) begin
          n.cmd   = wdata[7:0];
          n.state = pcs_pkg::PCS_DECODE;
        end
      end
      pcs_pkg::PCS_DECODE: begin
        n.state = pcs_pkg::PCS_DONE;
        // (R01) (R14) base = group offset + index * pitch
        n.fill_line = BW'(BW'(s.line_off) + BW'(row) * BW'(s.ins_lines));
        n.fill_pix  = BW'(BW'(s.pix_off) + BW'(col) * BW'(s.ins_pix));
        n.tbl_idx   = s.cmd[3:0];
        if (is_writer) begin
          unique case (opc)
            // (R04) background, framed
            pcs_pkg::OPC_FILL_BG: begin
              n.fill_kind  = pcs_pkg::FILL_BG;
              n.fill_start = 1'b1;
              n.state      = pcs_pkg::PCS_FILL;
            end
            // (R05) frame colour
            pcs_pkg::OPC_FRAME: begin
              n.fill_kind  = pcs_pkg::FILL_FRAME;
              n.fill_start = 1'b1;
              n.state      = pcs_pkg::PCS_FILL;
            end
            // (R16) background, no frame
            pcs_pkg::OPC_FILL_BG_NF: begin
              n.fill_kind  = pcs_pkg::FILL_BG_NF;
              n.fill_start = 1'b1;
              n.state      = pcs_pkg::PCS_FILL;
            end
            // (R06) live start, framed
            pcs_pkg::OPC_LIVE:    n.tbl_op = pcs_pkg::OP_START_FR;
            // (R16) live start, no frame
            pcs_pkg::OPC_LIVE_NF: n.tbl_op = pcs_pkg::OP_START_NF;
            // (R07) live stop freezes
            pcs_pkg::OPC_STOP:    n.tbl_op = pcs_pkg::OP_STOP;
            default: ;
          endcase
        end else if (is_main) begin
          // (R08) (R09) display on and off
          if (opc == pcs_pkg::OPC_DISP_ON) begin
            n.display_on = 1'b1;
          end else if (opc == pcs_pkg::OPC_DISP_OFF) begin
            n.display_on = 1'b0;
          end
        end
      end
      pcs_pkg::PCS_FILL: begin
        if (eng_done) begin
          n.state = pcs_pkg::PCS_DONE;
        end
      end
      pcs_pkg::PCS_DONE: begin
        n.state = pcs_pkg::PCS_IDLE;
      end
      default: n.state = pcs_pkg::PCS_IDLE;
    endcase

    // (R17) set wins over clear
    n.pending = (s.pending && s.state != pcs_pkg::PCS_DONE) || cmd_wr;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s           <= '0;
      s.state     <= pcs_pkg::PCS_IDLE;
      s.role      <= pcs_pkg::ROLE_RST;
      s.layout    <= pcs_pkg::LAYOUT_RST;
      // (R01) default group offsets zero
      s.line_off  <= pcs_pkg::GROUP_OFFSET_RST;
      s.pix_off   <= pcs_pkg::GROUP_OFFSET_RST;
      s.hstart    <= pcs_pkg::WINDOW_RST;
      s.vstart    <= pcs_pkg::WINDOW_RST;
      s.ins_lines <= pcs_pkg::INS_LINES_RST;
      s.ins_pix   <= pcs_pkg::INS_PIX_RST;
    end else begin
      s <= n;
    end
  end

  assign rdata                = s.rdata;
  assign command_pending_flag = s.pending;
  assign display_enable       = s.display_on;
  assign fill_busy            = eng_busy;
  assign fill_kind            = s.fill_kind;
  assign fill_line_base       = s.fill_line;
  assign fill_pixel_base      = s.fill_pix;
  assign horiz_window_start   = s.hstart;
  assign vert_window_start    = s.vstart;
  assign inset_layout_select  = s.layout;
  assign inset_live_mask      = live_mask;
  assign inset_framed_mask    = framed_mask;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic in_decode;
  assign in_decode = (s.state == pcs_pkg::PCS_DECODE);

  sequence seq_decode_writer(logic [3:0] code);
    in_decode && is_writer && opc == code;
  endsequence

  sequence seq_fill_started(logic [1:0] kind);
    ##1 (s.fill_kind == kind && s.fill_start) ##1 eng_busy;
  endsequence

  chk_pending_set: assert property ( // (R17)
    cmd_wr |=> command_pending_flag && (s.state == pcs_pkg::PCS_DECODE))
    else $error("pending not set by command write");

  // flag must cover the whole fill, or the host could overrun it
  chk_pending_hold: assert property ( // (R17)
    (s.state == pcs_pkg::PCS_FILL) |-> command_pending_flag)
    else $error("pending dropped during fill");

  chk_pending_clear: assert property ( // (R17)
    (s.state == pcs_pkg::PCS_DONE) |=> !command_pending_flag && s.state == pcs_pkg::PCS_IDLE)
    else $error("pending not cleared after command");

  chk_fill_background: assert property ( // (R04)
    seq_decode_writer(pcs_pkg::OPC_FILL_BG) |-> seq_fill_started(pcs_pkg::FILL_BG))
    else $error("background fill not started");

  chk_draw_frame: assert property ( // (R05)
    seq_decode_writer(pcs_pkg::OPC_FRAME) |-> seq_fill_started(pcs_pkg::FILL_FRAME))
    else $error("frame fill not started");

  chk_live_start: assert property ( // (R06)
    seq_decode_writer(pcs_pkg::OPC_LIVE) |-> ##2 (live_mask[s.cmd[3:0]] &&
                                                framed_mask[s.cmd[3:0]]))
    else $error("live framed write not started");

  chk_live_stop: assert property ( // (R07)
    seq_decode_writer(pcs_pkg::OPC_STOP) |-> ##2 !live_mask[s.cmd[3:0]]
                                           && $stable(framed_mask))
    else $error("live write not stopped");

  chk_display_on: assert property ( // (R08)
    in_decode && is_main && opc == pcs_pkg::OPC_DISP_ON |=> display_enable [*2])
    else $error("display not turned on");

  chk_display_off: assert property ( // (R09)
    in_decode && is_main && opc == pcs_pkg::OPC_DISP_OFF |=> !display_enable)
    else $error("display not turned off");

  chk_index_base: assert property ( // (R10)
    in_decode |=> fill_line_base == BW'(BW'($past(s.line_off)) +
                  BW'($past(row)) * BW'($past(s.ins_lines))))
    else $error("inset line base wrong");

  chk_noframe_live: assert property ( // (R16)
    seq_decode_writer(pcs_pkg::OPC_LIVE_NF) |-> ##2 (live_mask[s.cmd[3:0]] &&
                                                   !framed_mask[s.cmd[3:0]]))
    else $error("no-frame live write wrong");

  chk_window_move: assert property ( // (R13)
    wr && addr == pcs_pkg::HSTART_OFF |=> horiz_window_start == $past(wdata[PW-1:0]))
    else $error("window start not updated");

  // any value goes through, even one that misplaces the window
  chk_vert_unclamped: assert property ( // (R15)
    wr && addr == pcs_pkg::VSTART_OFF |=> vert_window_start == $past(wdata[PW-1:0]))
    else $error("vertical start altered");

  chk_pixel_base: assert property ( // (R10)
    in_decode |=> fill_pixel_base == BW'(BW'($past(s.pix_off)) +
                  BW'($past(col)) * BW'($past(s.ins_pix))))
    else $error("inset pixel base wrong");

  chk_fill_noframe: assert property ( // (R16)
    seq_decode_writer(pcs_pkg::OPC_FILL_BG_NF) |-> seq_fill_started(pcs_pkg::FILL_BG_NF))
    else $error("no-frame fill not started");

  // unknown role: command starts nothing, only the fill bases update and the flag clears
  chk_role_ignored: assert property ( // (R08)
    in_decode && !is_writer && !is_main |=> !s.fill_start &&
      s.tbl_op == pcs_pkg::OP_NONE && $stable(display_enable))
    else $error("command acted on without a role");
endmodule

// File: sim/pcs_host_model.sv
`timescale 1ns/1ns
module pcs_host_model (
  input  wire logic                       ref_clk,
  output logic [pcs_pkg::ADDR_W-1:0]      addr,
  output logic [pcs_pkg::DATA_W-1:0]      wdata,
  output logic                            wr,
  output logic                            rd,
  input  wire logic [pcs_pkg::DATA_W-1:0] rdata
);
  initial begin
    addr  = 6'h00;
    wdata = 16'h0000;
    wr    = 1'h0;
    rd    = 1'h0;
  end

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge ref_clk);
    wr    <= 1'h0;
    // released data must not look like the last value
    wdata <= ~d;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge ref_clk);
    rd   <= 1'h0;
    // sampled mid-cycle, clear of the update edge
    @(negedge ref_clk);
    d = rdata;
  endtask

  task automatic wait_idle(input int slow);
    logic [15:0] st;
    st = 16'h0001;
    // no local limit: a flag stuck high runs into the bench timeout
    while (st[pcs_pkg::ST_PENDING_BIT] !== 1'h0) begin
      repeat (slow) @(posedge ref_clk);
      rd_reg(pcs_pkg::STATUS_OFF, st);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input int slow);
    wr_reg(pcs_pkg::CMD_OFF, {8'h00, c});
    wait_idle(slow);
  endtask
endmodule

// File: sim/pcs_sequencer_tb.sv
`timescale 1ns/1ns
module pcs_sequencer_tb;
  logic                            ref_clk;
  logic                            reset_n;
  logic [pcs_pkg::ADDR_W-1:0]      addr;
  logic [pcs_pkg::DATA_W-1:0]      wdata;
  logic                            wr;
  logic                            rd;
  logic [pcs_pkg::DATA_W-1:0]      rdata;
  logic                            command_pending_flag;
  logic                            display_enable;
  logic                            fill_busy;
  logic [1:0]                      fill_kind;
  logic [pcs_pkg::BASE_W-1:0]      fill_line_base;
  logic [pcs_pkg::BASE_W-1:0]      fill_pixel_base;
  logic [pcs_pkg::POS_W-1:0]       horiz_window_start;
  logic [pcs_pkg::POS_W-1:0]       vert_window_start;
  logic [7:0]                      inset_layout_select;
  logic [pcs_pkg::NUM_INSETS-1:0]  inset_live_mask;
  logic [pcs_pkg::NUM_INSETS-1:0]  inset_framed_mask;
  int                              error_cnt = 0;
  int                              n_compared = 0;
  int                              cycles = 0;

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  pcs_host_model u_host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  // short fill so a run stays small
  pcs_sequencer #(.FILL_CYCLES(5)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .command_pending_flag(command_pending_flag), .display_enable(display_enable),
    .fill_busy(fill_busy), .fill_kind(fill_kind), .fill_line_base(fill_line_base),
    .fill_pixel_base(fill_pixel_base), .horiz_window_start(horiz_window_start),
    .vert_window_start(vert_window_start), .inset_layout_select(inset_layout_select),
    .inset_live_mask(inset_live_mask), .inset_framed_mask(inset_framed_mask));

  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd_reg(a, d);
    chk(d, exp);
  endtask

  task automatic fchk(input logic [1:0] k, input logic [11:0] lb, input logic [11:0] pb);
    chk({14'h0000, fill_kind}, {14'h0000, k});
    chk({4'h0, fill_line_base}, {4'h0, lb});
    chk({4'h0, fill_pixel_base}, {4'h0, pb});
  endtask

  task automatic t_reset_regs();
    rchk(pcs_pkg::INSLIN_OFF, 16'h0048);
    rchk(pcs_pkg::INSPIX_OFF, 16'h00b4);
    rchk(pcs_pkg::LINOFF_OFF, 16'h0000);
    rchk(pcs_pkg::PIXOFF_OFF, 16'h0000);
    rchk(6'h3c, 16'h0000);
    u_host.wr_reg(pcs_pkg::LIVE_OFF, 16'hffff);
    rchk(pcs_pkg::LIVE_OFF, 16'h0000);
  endtask

  task automatic t_fill();
    int n;
    u_host.wr_reg(pcs_pkg::ROLE_OFF, 16'h0001);
    u_host.wr_reg(pcs_pkg::CMD_OFF, 16'h00c0);
    #1 chk({15'h0000, command_pending_flag}, 16'h0001);
    // second command while pending must be dropped
    u_host.wr_reg(pcs_pkg::CMD_OFF, 16'h00a0);
    // step off the launching edge before looking at the engine
    @(negedge ref_clk);
    n = 0;
    while (fill_busy !== 1'h1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk({15'h0000, fill_busy}, 16'h0001);
    u_host.wait_idle(0);
    chk({15'h0000, command_pending_flag}, 16'h0000);
    fchk(pcs_pkg::FILL_BG, 12'h000, 12'h000);
    rchk(pcs_pkg::CMD_OFF, 16'h00c0);
    u_host.cmd(8'ha5, 0);
    fchk(pcs_pkg::FILL_FRAME, 12'h048, 12'h0b4);
    u_host.cmd(8'hd6, 3);
    fchk(pcs_pkg::FILL_BG_NF, 12'h048, 12'h168);
  endtask

  task automatic t_live();
    u_host.cmd(8'h85, 0);
    chk(inset_live_mask, 16'h0020);
    chk(inset_framed_mask, 16'h0020);
    u_host.cmd(8'he3, 0);
    chk(inset_live_mask, 16'h0028);
    chk(inset_framed_mask, 16'h0020);
    u_host.cmd(8'h95, 0);
    chk(inset_live_mask, 16'h0008);
    chk(inset_framed_mask, 16'h0020);
    u_host.wr_reg(pcs_pkg::HSTART_OFF, 16'h0101);
    u_host.wr_reg(pcs_pkg::VSTART_OFF, 16'h03ff);
    repeat (2) @(negedge ref_clk);
    chk({6'h00, horiz_window_start}, 16'h0101);
    chk({6'h00, vert_window_start}, 16'h03ff);
  endtask

  task automatic t_scan();
    logic [3:0] idx [4];
    idx = '{4'h0, 4'h1, 4'h4, 4'h5};
    for (int i = 0; i < 4; i++) begin
      u_host.cmd({4'h8, idx[i]}, i);
      chk(inset_live_mask, 16'h0008 | (16'h0001 << idx[i]));
      u_host.cmd({4'h9, idx[i]}, 0);
      chk(inset_live_mask, 16'h0008);
    end
  endtask

  task automatic t_group();
    u_host.wr_reg(pcs_pkg::LINOFF_OFF, 16'h02b8);
    u_host.cmd(8'hc4, 0);
    fchk(pcs_pkg::FILL_BG, 12'h300, 12'h000);
    u_host.wr_reg(pcs_pkg::PIXOFF_OFF, 16'h0010);
    u_host.cmd(8'hc5, 0);
    fchk(pcs_pkg::FILL_BG, 12'h300, 12'h0c4);
  endtask

  task automatic t_main();
    u_host.wr_reg(pcs_pkg::ROLE_OFF, 16'h0003);
    u_host.cmd(8'h80, 0);
    chk({15'h0000, display_enable}, 16'h0000);
    u_host.wr_reg(pcs_pkg::ROLE_OFF, 16'h0005);
    u_host.wr_reg(pcs_pkg::LAYOUT_OFF, 16'h0046);
    u_host.cmd(8'h80, 0);
    chk({15'h0000, display_enable}, 16'h0001);
    chk({8'h00, inset_layout_select}, 16'h0046);
    u_host.cmd(8'h90, 2);
    chk({15'h0000, display_enable}, 16'h0000);
  endtask

  initial begin
    reset_n = 1'h0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'h1;
    t_reset_regs();
    t_fill();
    t_live();
    t_scan();
    t_group();
    t_main();
    wrap_up();
  end
endmodule
